// [core/runtime_status_shadow_regs.sv]
// Runtime status, force-change and shadow register bank behind an AXI4-Lite slave
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`include "status_shadow_defs.svh"

module runtime_status_shadow_regs #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Grouped management irq sources
  input wire logic gpio_line_54,
  input wire logic gpio_line_55,
  input wire logic gpio_line_56,
  input wire logic gpio_line_57,
  input wire logic fan_speed_in_1,
  input wire logic fan_speed_in_2,
  output logic grouped_mgmt_irq,
  // Either-edge gpio inputs
  input wire logic gpio_line_21,
  input wire logic gpio_line_22,
  input wire logic gpio_line_41,
  input wire logic gpio_line_43,
  input wire logic gpio_line_60,
  input wire logic gpio_line_61,
  output logic edge_irq,
  // Floppy drive signals, active high here
  input wire logic head_step_strobe,
  input wire logic drive_select_0,
  input wire logic drive_select_1,
  input wire logic media_change_pin,
  output logic media_change_flag,
  output logic [1:0] forced_change
);

  // ****************************************
  // AXI4-Lite write side
  // ****************************************
  logic aw_held_r;
  logic w_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_fire;
  logic wr_lane0;

  // Address and data park until both are in; none taken while a response waits
  assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_r & ~s_axi_bvalid;
  assign wr_fire = aw_held_r & w_held_r & ~s_axi_bvalid;
  // Byte lane 0 carries the whole register
  assign wr_lane0 = wstrb_r[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end
  end

  // Register index is the byte address over four
  function automatic logic [7:0] word_ofs(input logic [ADDR_W-1:0] a);
    logic [9:0] wide;
    wide = 10'(a);
    return wide[9:2];
  endfunction

  // Indices of the bank, reserved gaps and write-only registers included
  function automatic logic known_ofs(input logic [7:0] o);
    return (o >= `OFS_IRQ_EN5) && (o <= `OFS_FIFO_WR);
  endfunction

  // Unmapped indices answer with a slave error
  logic wr_known;
  assign wr_known = known_ofs(word_ofs(awaddr_r));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_known ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  function automatic logic wr_hit(input logic fire, input logic [7:0] got, input logic [7:0] want,
                                  input logic lane);
    return fire && lane && (got == want);
  endfunction

  logic [7:0] wbyte;
  logic [7:0] wofs;
  assign wbyte = wdata_r[7:0];
  assign wofs = word_ofs(awaddr_r);

  // ****************************************
  // Enable register and grouped irq
  // ****************************************
  status_shadow_pkg::reg8_t irq_en5_r;
  status_shadow_pkg::reg8_t irq_mask_r;

  // Reserved bits 5:4 are dropped on write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en5_r <= `IRQ_EN5_RESET;
    end else if (wr_hit(wr_fire, wofs, `OFS_IRQ_EN5, wr_lane0)) begin
      irq_en5_r <= wbyte & `IRQ_EN5_MASK;
    end
  end

  // Sources line up with the enable bits; bits 5:4 have none
  logic [7:0] irq_src;
  assign irq_src = {fan_speed_in_2, fan_speed_in_1, 2'b00,
                    gpio_line_57, gpio_line_56, gpio_line_55, gpio_line_54};

  // Registered so the grouped irq cannot glitch as sources change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      grouped_mgmt_irq <= 1'b0;
    end else begin
      grouped_mgmt_irq <= |(irq_src & irq_en5_r);
    end
  end

  // ****************************************
  // Either-edge status
  // ****************************************
  logic [5:0] gpio_in;
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  logic [5:0] prev_r;
  logic [5:0] edge_hit;
  status_shadow_pkg::reg8_t edge_sts_r;
  logic [5:0] sts_clr;
  logic rd_clr_sts;

  // Status bit order of the either-edge inputs
  assign gpio_in[`EDGE_GPIO_LINE_21_BIT] = gpio_line_21;
  assign gpio_in[`EDGE_GPIO_LINE_22_BIT] = gpio_line_22;
  assign gpio_in[`EDGE_GPIO_LINE_41_BIT] = gpio_line_41;
  assign gpio_in[`EDGE_GPIO_LINE_43_BIT] = gpio_line_43;
  assign gpio_in[`EDGE_GPIO_LINE_60_BIT] = gpio_line_60;
  assign gpio_in[`EDGE_GPIO_LINE_61_BIT] = gpio_line_61;

  // Two-stage synchroniser; edges compare stage two against its previous value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= 6'h00;
      sync2_r <= 6'h00;
      prev_r <= 6'h00;
    end else begin
      sync1_r <= gpio_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // Held off until sync2_r and prev_r both hold samples taken after reset
  logic [1:0] arm_cnt_r;
  logic armed;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arm_cnt_r <= 2'h0;
    end else if (!armed) begin
      arm_cnt_r <= 2'(arm_cnt_r + 2'h1);
    end
  end

  assign armed = (arm_cnt_r == `EDGE_ARM_CYCLES);

  // Compare only once the pipeline holds real samples, so reset release is not an edge
  assign edge_hit = (sync2_r ^ prev_r) & {6{armed}};

  // Clear by a written one or by an accepted read of the status register
  assign sts_clr = (wr_hit(wr_fire, wofs, `OFS_EDGE_STS, wr_lane0) ? wbyte[5:0] : 6'h00)
                   | (rd_clr_sts ? 6'h3F : 6'h00);

  // A new edge wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      edge_sts_r <= `EDGE_STS_RESET;
    end else begin
      edge_sts_r <= {2'b00, (edge_sts_r[5:0] & ~sts_clr) | edge_hit};
    end
  end

  // Mask has the status layout; bits 7:6 cannot be set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_r <= `IRQ_MASK_RESET;
    end else if (wr_hit(wr_fire, wofs, `OFS_IRQ_MASK, wr_lane0)) begin
      irq_mask_r <= wbyte & `EDGE_STS_MASK;
    end
  end

  // Level interrupt, high while an unmasked status bit is set
  assign edge_irq = |(edge_sts_r & irq_mask_r);

  // ****************************************
  // Force media change
  // ****************************************
  status_shadow_pkg::reg8_t media_chg_r;
  logic [1:0] step_clr;

  // Step with a selected drive clears that drive's force bit
  assign step_clr = {head_step_strobe & drive_select_1, head_step_strobe & drive_select_0};

  // A software set wins over a step clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      media_chg_r <= `MEDIA_CHG_RESET;
    end else begin
      media_chg_r[1:0] <= (media_chg_r[1:0] & ~step_clr)
        | (wr_hit(wr_fire, wofs, `OFS_MEDIA_CHG, wr_lane0) ? wbyte[1:0] : 2'b00);
      media_chg_r[7:2] <= 6'h00;
    end
  end

  // Force bits go to the floppy controller as they stand
  assign forced_change = media_chg_r[1:0];

  // Disk-change bit seen by the floppy controller, one cycle behind its inputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      media_change_flag <= 1'b0;
    end else begin
      media_change_flag <= (drive_select_0 & media_chg_r[0])
        | (drive_select_1 & media_chg_r[1]) | media_change_pin;
    end
  end

  // ****************************************
  // Shadows of write-only control registers
  // ****************************************
  // Mirrors follow the write-only control registers; writes aimed at a mirror are dropped
  status_shadow_pkg::reg8_t rate_mirror_r;
  status_shadow_pkg::reg8_t fifo_mirror_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_mirror_r <= `MIRROR_RESET;
    end else if (wr_hit(wr_fire, wofs, `OFS_RATE_WR, wr_lane0)) begin
      rate_mirror_r <= {wbyte[7:6], 1'b0, wbyte[4:0]};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fifo_mirror_r <= `MIRROR_RESET;
    end else if (wr_hit(wr_fire, wofs, `OFS_FIFO_WR, wr_lane0)) begin
      fifo_mirror_r <= {wbyte[7:6], 2'b00, wbyte[3:0]};
    end
  end

  // ****************************************
  // AXI4-Lite read side
  // ****************************************
  status_shadow_pkg::rd_state_t rd_state_r;
  logic [7:0] rd_ofs;
  logic [7:0] rd_byte;

  assign rd_ofs = word_ofs(s_axi_araddr);
  assign s_axi_arready = (rd_state_r == status_shadow_pkg::RD_IDLE);
  // Status read clears at acceptance, after the old value is captured
  assign rd_clr_sts = s_axi_arvalid && s_axi_arready && (rd_ofs == `OFS_EDGE_STS);

  // Write-only control registers and unmapped indices read as zero
  always_comb begin
    rd_byte = 8'h00;
    unique case (rd_ofs)
      `OFS_IRQ_EN5: rd_byte = irq_en5_r;
      `OFS_EDGE_STS: rd_byte = edge_sts_r;
      `OFS_MEDIA_CHG: rd_byte = media_chg_r;
      `OFS_RATE_MIRROR: rd_byte = rate_mirror_r;
      `OFS_FIFO_MIRROR: rd_byte = fifo_mirror_r;
      `OFS_IRQ_MASK: rd_byte = irq_mask_r;
      `OFS_GAP_A: rd_byte = 8'h00;
      `OFS_GAP_B: rd_byte = 8'h00;
      default: rd_byte = 8'h00;
    endcase
  end

  // Read data is captured at acceptance and held until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_r <= status_shadow_pkg::RD_IDLE;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      unique case (rd_state_r)
        status_shadow_pkg::RD_IDLE: begin
          if (s_axi_arvalid) begin
            rd_state_r <= status_shadow_pkg::RD_RESP;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= known_ofs(rd_ofs) ? 2'h0 : 2'h2;
          end
        end
        status_shadow_pkg::RD_RESP: begin
          if (s_axi_rready) begin
            rd_state_r <= status_shadow_pkg::RD_IDLE;
          end
        end
        default: rd_state_r <= status_shadow_pkg::RD_IDLE;
      endcase
    end
  end

  // Valid for as long as the response waits for rready
  assign s_axi_rvalid = (rd_state_r == status_shadow_pkg::RD_RESP);

endmodule

// [core/status_shadow_defs.svh]
// Register offsets, field positions and reset values of the status and shadow bank
`ifndef STATUS_SHADOW_DEFS_SVH
`define STATUS_SHADOW_DEFS_SVH

`define OFS_IRQ_EN5 8'h1A
`define OFS_GAP_A 8'h1B
`define OFS_EDGE_STS 8'h1C
`define OFS_GAP_B 8'h1D
`define OFS_MEDIA_CHG 8'h1E
`define OFS_RATE_MIRROR 8'h1F
`define OFS_FIFO_MIRROR 8'h20
`define OFS_IRQ_MASK 8'h21
`define OFS_RATE_WR 8'h22
`define OFS_FIFO_WR 8'h23

`define IRQ_EN5_MASK 8'hCF
`define EDGE_STS_MASK 8'h3F
`define MEDIA_CHG_MASK 8'h03
`define IRQ_EN5_RESET 8'h00
`define EDGE_STS_RESET 8'h00
`define MEDIA_CHG_RESET 8'h01
`define MIRROR_RESET 8'h00
`define IRQ_MASK_RESET 8'h00
`define EDGE_ARM_CYCLES 2'h3

`define EDGE_GPIO_LINE_21_BIT 0
`define EDGE_GPIO_LINE_22_BIT 1
`define EDGE_GPIO_LINE_41_BIT 2
`define EDGE_GPIO_LINE_43_BIT 3
`define EDGE_GPIO_LINE_60_BIT 4
`define EDGE_GPIO_LINE_61_BIT 5
`define MEDIA_FLAG_BIT 7

`endif

// [core/status_shadow_pkg.sv]
// Types of the status and shadow bank
package status_shadow_pkg;
  typedef logic [7:0] reg8_t;
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_RESP = 2'b01
  } rd_state_t;
endpackage

// [test/status_shadow_asserts.sv]
// Port checks of the status and shadow register bank
`timescale 1ns/1ps

module status_shadow_asserts #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  // Register bus
  input logic [ADDR_W-1:0] s_axi_araddr,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic s_axi_wvalid,
  input logic s_axi_bvalid,
  // Grouped irq
  input logic gpio_line_54,
  input logic gpio_line_55,
  input logic gpio_line_56,
  input logic gpio_line_57,
  input logic fan_speed_in_1,
  input logic fan_speed_in_2,
  input logic grouped_mgmt_irq,
  // Floppy drive
  input logic head_step_strobe,
  input logic drive_select_0,
  input logic drive_select_1,
  input logic media_change_pin,
  input logic media_change_flag,
  input logic [1:0] forced_change
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic rd_go;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  a_flag_formula: assert property ($past(aresetn) |-> media_change_flag ==
    $past(drive_select_0 & forced_change[0] | drive_select_1 & forced_change[1] | media_change_pin))
    else $error("Media change flag mismatch");
  a_force_reset: assert property (!$past(aresetn) |-> forced_change == 2'h1)
    else $error("Force register reset value wrong");
  a_step_clear0: assert property (head_step_strobe && drive_select_0 && !s_axi_wvalid
    && !$past(s_axi_wvalid) |=> !forced_change[0]) else $error("Force bit 0 not cleared");
  a_step_clear1: assert property (head_step_strobe && drive_select_1 && !s_axi_wvalid
    && !$past(s_axi_wvalid) |=> !forced_change[1]) else $error("Force bit 1 not cleared");
  a_force_sticky: assert property ($past(aresetn) && $fell(forced_change[0]) |->
    $past(head_step_strobe && drive_select_0)) else $error("Force bit 0 dropped");
  a_gap_zero: assert property (rd_go && (s_axi_araddr[7:2] == 6'h1B ||
    s_axi_araddr[7:2] == 6'h1D) |=> s_axi_rdata == 32'h0) else $error("Gap read not zero");
  a_status_top: assert property (rd_go && s_axi_araddr[7:2] == 6'h1C |=>
    s_axi_rdata[7:6] == 2'h0) else $error("Status bits 7:6 not zero");
  a_fifo_rsvd: assert property (rd_go && s_axi_araddr[7:2] == 6'h20 |=>
    s_axi_rdata[5:4] == 2'h0) else $error("Fifo mirror bits 5:4 not zero");
  a_irq_quiet: assert property ($past(aresetn) && !$past(gpio_line_54 | gpio_line_55 |
    gpio_line_56 | gpio_line_57 | fan_speed_in_1 | fan_speed_in_2) |-> !grouped_mgmt_irq)
    else $error("Grouped irq without source");
  c_write: cover property (s_axi_bvalid);
  c_flag: cover property (media_change_flag);
  c_clear: cover property ($fell(forced_change[1]));
endmodule

bind runtime_status_shadow_regs status_shadow_asserts #(.ADDR_W(ADDR_W)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_bvalid(s_axi_bvalid), .gpio_line_54(gpio_line_54), .gpio_line_55(gpio_line_55),
  .gpio_line_56(gpio_line_56), .gpio_line_57(gpio_line_57), .fan_speed_in_1(fan_speed_in_1),
  .fan_speed_in_2(fan_speed_in_2), .grouped_mgmt_irq(grouped_mgmt_irq),
  .head_step_strobe(head_step_strobe), .drive_select_0(drive_select_0),
  .drive_select_1(drive_select_1), .media_change_pin(media_change_pin),
  .media_change_flag(media_change_flag), .forced_change(forced_change));

// [test/test_runtime_status_shadow_regs.sv]
// Directed bench for the status and shadow register bank
`timescale 1ns/1ps

module test_runtime_status_shadow_regs;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdata;
  logic awr, wrdy, bv, arr, rv, irq, eirq, flag;
  logic [1:0] bresp, rresp, wresp, fc;
  logic [5:0] src = 0, g = 0;
  logic step = 0, sel0 = 0, sel1 = 0, pin = 0;
  int num_errors = 0, total_checks = 0;

  always #10 aclk = ~aclk;

  runtime_status_shadow_regs #(.ADDR_W(8)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .gpio_line_54(src[0]),
    .gpio_line_55(src[1]), .gpio_line_56(src[2]), .gpio_line_57(src[3]),
    .fan_speed_in_1(src[4]), .fan_speed_in_2(src[5]), .grouped_mgmt_irq(irq),
    .gpio_line_21(g[0]), .gpio_line_22(g[1]), .gpio_line_41(g[2]), .gpio_line_43(g[3]),
    .gpio_line_60(g[4]), .gpio_line_61(g[5]), .edge_irq(eirq), .head_step_strobe(step),
    .drive_select_0(sel0), .drive_select_1(sel1), .media_change_pin(pin),
    .media_change_flag(flag), .forced_change(fc));

  task automatic conclude;
    $display("Checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Handshakes are judged mid-cycle, the value the next rising edge samples
  task automatic xfer(input logic wr, input logic [7:0] i, input logic [7:0] d);
    int n;
    logic a, w, r;
    n = 0;
    r = 0;
    if (wr) begin
      awa <= {i[5:0], 2'b00};
      wd <= {24'h0, d};
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
    end else begin
      ara <= {i[5:0], 2'b00};
      arv <= 1'b1;
      rr <= 1'b1;
    end
    while (!r) begin
      @(negedge aclk);
      a = wr ? awv && awr : arv && arr;
      w = wv && wrdy;
      r = wr ? bv : rv;
      if (r) wresp = wr ? bresp : rresp;
      if (r && !wr) chk(rdata, {24'h0, d});
      @(posedge aclk);
      if (a && wr) awv <= 1'b0;
      if (a && !wr) arv <= 1'b0;
      if (w) wv <= 1'b0;
      if (r) {br, rr} <= 2'b00;
      if (++n > 40) begin
        chk(32'h0, 32'h1);
        conclude();
      end
    end
    @(posedge aclk);
  endtask

  task automatic flags(input logic [1:0] f, input logic fl);
    chk({30'h0, fc}, {30'h0, f});
    chk({31'h0, flag}, {31'h0, fl});
  endtask

  initial begin
    wt(10);
    aresetn <= 1'b1;
    @(posedge aclk);
    xfer(0, 8'h1A, 8'h00);
    xfer(0, 8'h1C, 8'h00);
    xfer(0, 8'h1E, 8'h01);
    xfer(1, 8'h1A, 8'hFF);
    xfer(0, 8'h1A, 8'hCF);
    xfer(1, 8'h1B, 8'hFF);
    xfer(0, 8'h1B, 8'h00);
    xfer(0, 8'h1D, 8'h00);
    for (int k = 0; k < 6; k++) begin
      xfer(1, 8'h1A, 8'h01 << (k < 4 ? k : k + 2));
      src <= ~(6'h01 << k);
      wt(3);
      chk({31'h0, irq}, 32'h0);
      src <= 6'h01 << k;
      wt(3);
      chk({31'h0, irq}, 32'h1);
    end
    src <= 6'h00;
    xfer(1, 8'h21, 8'h3F);
    for (int k = 0; k < 6; k++) begin
      g[k] <= ~g[k];
      wt(5);
      chk({31'h0, eirq}, 32'h1);
      xfer(0, 8'h1C, 8'h01 << k);
      xfer(0, 8'h1C, 8'h00);
      g[k] <= ~g[k];
      wt(5);
      xfer(1, 8'h1C, 8'h00);
      xfer(0, 8'h1C, 8'h01 << k);
      g[k] <= ~g[k];
      wt(5);
      xfer(1, 8'h1C, 8'hFF);
      xfer(0, 8'h1C, 8'h00);
    end
    xfer(1, 8'h21, 8'h00);
    g <= 6'h00;
    wt(5);
    chk({31'h0, eirq}, 32'h0);
    xfer(0, 8'h1C, 8'h3F);
    sel0 <= 1'b1;
    wt(2);
    flags(2'h1, 1'b1);
    step <= 1'b1;
    wt(1);
    step <= 1'b0;
    wt(2);
    flags(2'h0, 1'b0);
    xfer(1, 8'h1E, 8'hFE);
    xfer(0, 8'h1E, 8'h02);
    xfer(1, 8'h1E, 8'h00);
    xfer(0, 8'h1E, 8'h02);
    step <= 1'b1;
    wt(1);
    {step, sel0, sel1} <= 3'b001;
    wt(2);
    flags(2'h2, 1'b1);
    step <= 1'b1;
    wt(1);
    {step, sel1, pin} <= 3'b001;
    wt(2);
    flags(2'h0, 1'b1);
    xfer(1, 8'h22, 8'hFF);
    xfer(0, 8'h1F, 8'hDF);
    xfer(1, 8'h23, 8'hFF);
    xfer(0, 8'h20, 8'hCF);
    xfer(1, 8'h1F, 8'h00);
    xfer(0, 8'h1F, 8'hDF);
    xfer(1, 8'h22, 8'h5A);
    xfer(0, 8'h1F, 8'h5A);
    chk({30'h0, wresp}, 32'h0);
    xfer(1, 8'h10, 8'h00);
    chk({30'h0, wresp}, 32'h2);
    xfer(0, 8'h10, 8'h00);
    chk({30'h0, wresp}, 32'h2);
    // Mid-run reset with every edge input high: release must not count as an edge
    g <= 6'h3F;
    aresetn <= 1'b0;
    wt(3);
    aresetn <= 1'b1;
    wt(6);
    xfer(0, 8'h1C, 8'h00);
    xfer(0, 8'h1E, 8'h01);
    conclude();
  end
endmodule
